// ### bench/sdc_ctrl_tb_top.sv
`timescale 1ns/1ps
module sdc_ctrl_tb_top;
  import sdc_pkg::*;
  localparam int PU = 20;
  localparam int REFC = 60;
  logic clk, rst, req_valid, req_auto_pre, req_ready, rd_valid, init_done;
  logic mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_dq_oe;
  logic [1:0] req_op, req_mask, mem_dqm;
  logic [20:0] req_addr;
  logic [15:0] req_wdata, rd_data, mem_dq_out, mem_dq_in;
  logic [11:0] mem_addr;
  logic [28:0] w;
  logic [31:0] r;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int err_count;
  int seed = 32'h8E84DE93;
  logic [15:0] shadow [int];
  logic [15:0] rq [$];
  logic [28:0] wq [$];

  sdc_ctrl #(.POWERUP_CYCLES(PU), .REFRESH_CYCLES(REFC)) u_dut (
    .CLK(clk), .RST(rst), .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_MASK(req_mask), .REQ_AUTO_PRE(req_auto_pre), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid), .INIT_DONE(init_done),
    .MEM_CKE(mem_cke), .MEM_CS_N(mem_cs_n), .MEM_RAS_N(mem_ras_n), .MEM_CAS_N(mem_cas_n),
    .MEM_WE_N(mem_we_n), .MEM_ADDR(mem_addr), .MEM_DQM(mem_dqm), .MEM_DQ_OUT(mem_dq_out),
    .MEM_DQ_OE(mem_dq_oe), .MEM_DQ_IN(mem_dq_in));

  sdc_mem_model #(.REF_MAX(REFC)) u_mem (
    .clk(clk), .cke(mem_cke), .cs_n(mem_cs_n), .ras_n(mem_ras_n), .cas_n(mem_cas_n),
    .we_n(mem_we_n), .addr(mem_addr), .dqm(mem_dqm), .dq_out(mem_dq_out),
    .dq_in(mem_dq_in), .err_count(err_count));

  // *****
  // Clock and hang guard
  // *****
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // *****
  // Shared tasks
  // *****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Ready is sampled just before the edge, so the edge's own updates never race it
  task automatic req(input logic [1:0] op, input logic [20:0] a, input logic [15:0] d,
                     input logic [1:0] m, input logic ap);
    logic rdy;
    logic [15:0] old;
    int n;
    @(negedge clk);
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_mask = m;
    req_auto_pre = ap;
    req_valid = 1'b1;
    rdy = 1'b0;
    n = 0;
    while (rdy !== 1'b1 && n < 300) begin
      #19;
      rdy = req_ready;
      @(posedge clk);
      if (rdy !== 1'b1) @(negedge clk);
      n++;
    end
    check({31'h0, rdy}, 32'h1);
    old = shadow.exists(int'(a)) ? shadow[int'(a)] : 16'h0000;
    if (op == REQ_RD) begin
      rq.push_back(old);
    end else begin
      wq.push_back({a[20], ap, a[8:0], d, m});
      shadow[int'(a)] = {m[1] ? old[15:8] : d[15:8], m[0] ? old[7:0] : d[7:0]};
    end
  endtask

  task automatic idle(input int n);
    @(negedge clk);
    req_valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask

  task automatic wait_init();
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check({31'h0, n > PU}, 32'h1);
  endtask

  // *****
  // Result watcher
  // *****
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      if (rq.size() == 0) check(32'h1, 32'h0);
      else check({16'h0, rd_data}, {16'h0, rq.pop_front()});
    end
    if (mem_cke === 1'b1 && {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} === CMD_WR) begin
      w = (wq.size() == 0) ? 29'h0 : wq.pop_front();
      check({mem_addr[11], mem_addr[10], mem_addr[8:0]}, {w[28], w[27], w[26:18]});
      check({mem_dq_oe, mem_dq_out, mem_dqm}, {1'b1, w[17:0]});
    end
  end

  // *****
  // Main sequence
  // *****
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = REQ_RD;
    req_addr = 21'h000000;
    req_wdata = 16'h0000;
    req_mask = 2'h0;
    req_auto_pre = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    wait_init();
    $display("test power-up done");
    for (int i = 0; i < 4; i++) req(REQ_WR, {12'h00A, 9'(i)}, 16'($random(seed)), 2'h0, 1'b0);
    for (int i = 0; i < 4; i++) req(REQ_RD, {12'h00A, 9'(i)}, 16'h0000, 2'h0, 1'b0);
    idle(12);
    $display("test row hits done");
    for (int m = 0; m < 4; m++) req(REQ_WR, 21'h1000A5, 16'($random(seed)), 2'(m), 1'b0);
    req(REQ_RD, 21'h1000A5, 16'h0000, 2'h0, 1'b1);
    idle(12);
    $display("test byte masks done");
    for (int i = 0; i < 64; i++) begin
      r = $random(seed);
      req(r[0] ? REQ_RD : REQ_WR, {r[1], 9'h000, r[3:2], 4'h0, r[8:4]}, r[31:16],
          r[0] ? 2'h0 : r[11:10], r[9]);
    end
    idle(12);
    $display("test random traffic done");
    idle(4 * REFC);
    foreach (shadow[a]) req(REQ_RD, 21'(a), 16'h0000, 2'h0, 1'b0);
    idle(12);
    $display("test refresh retention done");
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    wait_init();
    req(REQ_WR, 21'h0AB00F, 16'hC35A, 2'h0, 1'b1);
    req(REQ_RD, 21'h0AB00F, 16'h0000, 2'h0, 1'b0);
    idle(12);
    $display("test second reset done");
    check(32'(rq.size() + wq.size()), 32'h0);
    check(32'(err_count), 32'h0);
    end_sim();
  end
endmodule

// ### bench/sdc_mem_model.sv
`timescale 1ns/1ps
module sdc_mem_model
  import sdc_pkg::*;
#(
  parameter int REF_MAX = 60
) (
  // Clock
  input wire logic clk,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic [1:0] dqm,
  input wire logic [15:0] dq_out,
  // Data returned and faults seen
  output logic [15:0] dq_in,
  output int err_count
);
  logic [15:0] mem [int];
  logic is_open [2] = '{1'b0, 1'b0};
  logic [10:0] row [2] = '{11'h000, 11'h000};
  int t_act [2] = '{-99, -99};
  int t_pre [2] = '{-99, -99};
  int t_wr [2] = '{-99, -99};
  int t_wap [2] = '{-99, -99};
  int cyc = 0;
  int t_any = -99;
  int t_ref = -99;
  int t_mrs = -99;
  int t_cke = -99;
  int k;
  logic [16:0] pipe [3] = '{default: '0};
  logic [1:0] dqm_q = 2'h0;
  logic cke_q = 1'b0;
  logic mode_set = 1'b0;
  logic b;
  logic [3:0] cmd;
  logic [15:0] old;

  task automatic flag(input int code);
    err_count++;
    $display("protocol fault at %0t code %0d", $time, code);
  endtask

  initial begin
    err_count = 0;
    dq_in = 16'h0000;
  end

  always @(posedge clk) begin
    cmd = {cs_n, ras_n, cas_n, we_n};
    b = addr[BANK_SELECT_BIT];
    if (cke && !cke_q) t_cke = cyc;
    if (!cke) mode_set = 1'b0;
    cke_q = cke;
    // Word leaves three edges after its read; masks act two edges late
    pipe[2] = pipe[1];
    pipe[1] = pipe[0];
    pipe[0] = '0;
    if (pipe[2][16]) begin
      dq_in[15:8] <= dqm_q[1] ? ~dq_in[15:8] : pipe[2][15:8];
      dq_in[7:0] <= dqm_q[0] ? ~dq_in[7:0] : pipe[2][7:0];
    end else begin
      // A floated bus must never look like held data
      dq_in <= ~dq_in;
    end
    dqm_q = dqm;
    if (mode_set && cyc - t_ref == REF_MAX + 16) flag(10);
    if (cke && !cs_n && cmd != CMD_NOP) begin
      if (cyc - t_cke < CKA_CYC) flag(7);
      if (cyc - t_mrs < MODE_LOAD_RECOVERY_CYC) flag(20);
      if (cyc - t_ref < RC_CYC) flag(1);
      k = int'({b, row[b], addr[9:0]});
      case (cmd)
        CMD_ACT: begin
          if (!mode_set) flag(21);
          if (is_open[b]) flag(24);
          if (cyc - t_act[b] < RC_CYC) flag(1);
          if (cyc - t_pre[b] < RP_CYC) flag(3);
          if (cyc - t_any < RRD_CYC) flag(5);
          if (cyc - t_wap[b] < DAL_CYC) flag(9);
          is_open[b] = 1'b1;
          row[b] = addr[10:0];
          t_act[b] = cyc;
          t_any = cyc;
        end
        CMD_RD, CMD_WR: begin
          if (!is_open[b]) flag(24);
          if (cyc - t_act[b] < RCD_CYC) flag(4);
          old = mem.exists(k) ? mem[k] : 16'h0000;
          // One word per column command, taken in its own cycle only
          if (cmd == CMD_RD) begin
            pipe[0] = {1'b1, old};
          end else begin
            mem[k] = {dqm[1] ? old[15:8] : dq_out[15:8], dqm[0] ? old[7:0] : dq_out[7:0]};
            t_wr[b] = cyc;
          end
          // Row closes at once, ahead of the last word
          if (addr[AUTOPRECHARGE_SELECT_BIT]) begin
            is_open[b] = 1'b0;
            t_pre[b] = cyc;
            if (cmd == CMD_WR) t_wap[b] = cyc;
          end
        end
        CMD_PRE: begin
          for (int i = 0; i < 2; i++) begin
            if (addr[AUTOPRECHARGE_SELECT_BIT] || b == i[0]) begin
              if (is_open[i] && cyc - t_act[i] < RAS_CYC) flag(2);
              if (cyc - t_wr[i] < WRITE_RECOVERY_CYC) flag(8);
              is_open[i] = 1'b0;
              t_pre[i] = cyc;
            end
          end
        end
        CMD_REF: begin
          if (is_open[0] || is_open[1]) flag(24);
          t_ref = cyc;
        end
        CMD_MRS: begin
          if (is_open[0] || is_open[1]) flag(24);
          mode_set = 1'b1;
          t_mrs = cyc;
        end
        default: ;
      endcase
    end
    cyc = cyc + 1;
  end
endmodule

// ### core/sdc_bank.sv
`timescale 1ns/1ps
module sdc_bank
  import sdc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command events for this bank
  sdc_bank_if.bank bif
);
  logic [7:0] rc_cnt;
  logic [7:0] ras_cnt;
  logic [7:0] rcd_cnt;
  logic [7:0] rp_cnt;

  // Counters load on the event and count down to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rc_cnt <= 8'h00;
      ras_cnt <= 8'h00;
      rcd_cnt <= 8'h00;
      rp_cnt <= 8'h00;
    end else begin
      if (bif.act) begin
        rc_cnt <= 8'(RC_CYC - 1);
        ras_cnt <= 8'(RAS_CYC - 1);
        rcd_cnt <= 8'(RCD_CYC - 1);
      end else begin
        if (rc_cnt != 8'h00) rc_cnt <= rc_cnt - 8'h01;
        if (ras_cnt != 8'h00) ras_cnt <= ras_cnt - 8'h01;
        if (rcd_cnt != 8'h00) rcd_cnt <= rcd_cnt - 8'h01;
      end
      if (bif.pre) begin
        rp_cnt <= 8'(RP_CYC - 1);
      end else if (bif.col_wr) begin
        // Write burst of one: recovery before precharge or auto-precharge
        rp_cnt <= bif.auto_pre ? 8'(DAL_CYC) : 8'(WRITE_RECOVERY_CYC);
      end else if (rp_cnt != 8'h00) begin
        rp_cnt <= rp_cnt - 8'h01;
      end
    end
  end

  assign bif.can_act = (rc_cnt == 8'h00) && (rp_cnt == 8'h00);
  assign bif.can_pre = (ras_cnt == 8'h00) && (rp_cnt == 8'h00);
  assign bif.can_col = (rcd_cnt == 8'h00);

  // Spacings come from the clock period, so check the gating rather than fixed counts
  a_act_spacing: assert property (@(posedge clk) disable iff (rst)
    bif.act |-> bif.can_act) else $error("activate spacing too short");
  a_rcd_spacing: assert property (@(posedge clk) disable iff (rst)
    bif.col_wr |-> bif.can_col) else $error("activate to column too short");
endmodule

// ### core/sdc_ctrl.sv
`timescale 1ns/1ps
module sdc_ctrl
  import sdc_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int REFRESH_CYCLES = REFRESH_INTERVAL_CYC,
  parameter int ROW_OPEN_MAX = RAS_MAX_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // User request
  input wire logic [1:0] REQ_OP,
  input wire logic [20:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  input wire logic [1:0] REQ_MASK,
  input wire logic REQ_AUTO_PRE,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  output logic [15:0] RD_DATA,
  output logic RD_VALID,
  output logic INIT_DONE,
  // Memory pins
  output logic MEM_CKE,
  output logic MEM_CS_N,
  output logic MEM_RAS_N,
  output logic MEM_CAS_N,
  output logic MEM_WE_N,
  output logic [11:0] MEM_ADDR,
  output logic [1:0] MEM_DQM,
  output logic [15:0] MEM_DQ_OUT,
  output logic MEM_DQ_OE,
  input wire logic [15:0] MEM_DQ_IN
);
  // ****************************************
  // State machine
  // ****************************************
  typedef enum logic [6:0] {
    S_WAIT = 7'h01, S_PREALL = 7'h02, S_REF = 7'h04, S_MODE = 7'h08,
    S_IDLE = 7'h10, S_ACT = 7'h20, S_COL = 7'h40
  } sdc_state_t;

  sdc_state_t state;
  logic [31:0] wait_cnt;
  logic [31:0] ref_cnt;
  logic [31:0] open_cnt;
  logic [3:0] init_refs;
  logic ref_due;
  logic [1:0] open_bank;
  logic [10:0] open_row [2];
  logic [7:0] rrd_cnt;
  logic [7:0] mrs_cnt;
  logic [7:0] cke_cnt;
  logic [5:0] rd_pipe;
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  logic [1:0] bank_act;
  logic [1:0] bank_pre;
  logic [3:0] cmd;
  logic [11:0] addr;
  logic busy;
  logic req_bank;
  logic hit;

  sdc_bank_if bif0 ();
  sdc_bank_if bif1 ();

  function automatic logic [11:0] pre_addr(input logic all, input logic bank);
    pre_addr = 12'h000;
    pre_addr[AUTOPRECHARGE_SELECT_BIT] = all;
    pre_addr[BANK_SELECT_BIT] = bank;
  endfunction

  assign req_bank = REQ_ADDR[20];
  assign hit = open_bank[req_bank] && (open_row[req_bank] == REQ_ADDR[19:9]);
  assign busy = (mrs_cnt != 8'h00) || (cke_cnt != 8'h00);

  sdc_bank u_bank0 (.clk(CLK), .rst(RST), .bif(bif0));
  sdc_bank u_bank1 (.clk(CLK), .rst(RST), .bif(bif1));

  assign bif0.act = bank_act[0];
  assign bif1.act = bank_act[1];
  assign bif0.pre = bank_pre[0];
  assign bif1.pre = bank_pre[1];
  assign bif0.col_wr = (cmd == CMD_WR) && !addr[BANK_SELECT_BIT];
  assign bif1.col_wr = (cmd == CMD_WR) && addr[BANK_SELECT_BIT];
  assign bif0.auto_pre = addr[AUTOPRECHARGE_SELECT_BIT];
  assign bif1.auto_pre = addr[AUTOPRECHARGE_SELECT_BIT];

  // ****************************************
  // Command selection
  // ****************************************
  logic can_act_req;
  logic can_pre_req;
  logic can_col_req;
  logic can_all;
  assign can_act_req = (req_bank ? bif1.can_act : bif0.can_act) && (rrd_cnt == 8'h00);
  assign can_pre_req = req_bank ? bif1.can_pre : bif0.can_pre;
  assign can_col_req = req_bank ? bif1.can_col : bif0.can_col;
  assign can_all = bif0.can_act && bif1.can_act && bif0.can_pre && bif1.can_pre;

  // Column command goes out the cycle it is accepted; back to back allowed
  // Writes wait out a read's data slot: their mask would hide it, their drive would clash
  assign REQ_READY = (state == S_IDLE) && !busy && !ref_due && REQ_VALID
                     && hit && can_col_req
                     && !(REQ_OP == REQ_WR && rd_pipe[1:0] != 2'b00);

  always_comb begin
    cmd = CMD_NOP;
    addr = 12'h000;
    bank_act = 2'b00;
    bank_pre = 2'b00;
    if (!busy) begin
      case (state)
        S_PREALL: begin
          if (wait_cnt == 0 && can_all) begin
            cmd = CMD_PRE;
            addr = pre_addr(1'b1, 1'b0);
            bank_pre = 2'b11;
          end
        end
        S_REF: begin
          if (can_all) begin
            cmd = CMD_REF;
            bank_act = 2'b11;
          end
        end
        S_MODE: begin
          // Mode load waits out the last init refresh
          if (can_all) begin
            cmd = CMD_MRS;
            addr = MODE_WORD;
          end
        end
        S_IDLE: begin
          if (ref_due || open_cnt >= 32'(ROW_OPEN_MAX)) begin
            if (open_bank != 2'b00 && can_all) begin
              cmd = CMD_PRE;
              addr = pre_addr(1'b1, 1'b0);
              bank_pre = 2'b11;
            end
          end else if (REQ_VALID && REQ_OP != 2'h0) begin
            if (REQ_READY) begin
              cmd = (REQ_OP == REQ_WR) ? CMD_WR : CMD_RD;
              addr = {req_bank, REQ_AUTO_PRE, 1'b0, REQ_ADDR[8:0]};
            end else if (open_bank[req_bank] && !hit && can_pre_req) begin
              cmd = CMD_PRE;
              addr = pre_addr(1'b0, req_bank);
              bank_pre[req_bank] = 1'b1;
            end else if (!open_bank[req_bank] && can_act_req) begin
              cmd = CMD_ACT;
              addr = {req_bank, REQ_ADDR[19:9]};
              bank_act[req_bank] = 1'b1;
            end
          end
        end
        default: begin
          cmd = CMD_NOP;
        end
      endcase
    end
  end

  // ****************************************
  // Sequencing and timers
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= S_WAIT;
      wait_cnt <= 32'h0;
      init_refs <= 4'h0;
      INIT_DONE <= 1'b0;
      MEM_CKE <= 1'b0;
      cke_cnt <= 8'h00;
    end else begin
      if (cke_cnt != 8'h00) cke_cnt <= cke_cnt - 8'h01;
      case (state)
        S_WAIT: begin
          if (wait_cnt >= 32'(POWERUP_CYCLES)) begin
            state <= S_PREALL;
            wait_cnt <= 32'h0;
            MEM_CKE <= 1'b1;
            cke_cnt <= 8'(CKA_CYC);
          end else begin
            wait_cnt <= wait_cnt + 32'h1;
          end
        end
        S_PREALL: if (cmd == CMD_PRE) state <= S_REF;
        S_REF: begin
          if (cmd == CMD_REF) begin
            init_refs <= init_refs + 4'h1;
            if (INIT_DONE) state <= S_IDLE;
            else if (init_refs == 4'(INIT_REFRESHES - 1)) state <= S_MODE;
          end
        end
        S_MODE: begin
          if (cmd == CMD_MRS) begin
            state <= S_IDLE;
            INIT_DONE <= 1'b1;
          end
        end
        S_IDLE: if (ref_due && open_bank == 2'b00) state <= S_REF;
        default: state <= S_WAIT;
      endcase
    end
  end

  // Refresh cadence; ref_due clears only as the refresh issues
  always_ff @(posedge CLK) begin
    if (RST) begin
      ref_cnt <= 32'h0;
      ref_due <= 1'b0;
    end else begin
      if (cmd == CMD_REF) ref_due <= 1'b0;
      if (ref_cnt >= 32'(REFRESH_CYCLES - 1)) begin
        ref_cnt <= 32'h0;
        if (INIT_DONE) ref_due <= 1'b1;
      end else begin
        ref_cnt <= ref_cnt + 32'h1;
      end
    end
  end

  // Row tracking, bank-to-bank and mode-load spacing
  always_ff @(posedge CLK) begin
    if (RST) begin
      open_bank <= 2'b00;
      open_row[0] <= 11'h000;
      open_row[1] <= 11'h000;
      open_cnt <= 32'h0;
      rrd_cnt <= 8'h00;
      mrs_cnt <= 8'h00;
    end else begin
      if (rrd_cnt != 8'h00) rrd_cnt <= rrd_cnt - 8'h01;
      if (mrs_cnt != 8'h00) mrs_cnt <= mrs_cnt - 8'h01;
      open_cnt <= (open_bank != 2'b00) ? open_cnt + 32'h1 : 32'h0;
      if (cmd == CMD_MRS) mrs_cnt <= 8'(MODE_LOAD_RECOVERY_CYC - 1);
      if (cmd == CMD_ACT) begin
        open_bank[addr[BANK_SELECT_BIT]] <= 1'b1;
        open_row[addr[BANK_SELECT_BIT]] <= addr[10:0];
        rrd_cnt <= 8'(RRD_CYC - 1);
      end
      open_bank <= (open_bank | (cmd == CMD_ACT ? (2'b01 << addr[BANK_SELECT_BIT]) : 2'b00))
                   & ~bank_pre;
      if ((cmd == CMD_RD || cmd == CMD_WR) && addr[AUTOPRECHARGE_SELECT_BIT])
        open_bank[addr[BANK_SELECT_BIT]] <= 1'b0;
    end
  end

  // ****************************************
  // Pins and read capture
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= CMD_NOP;
      MEM_ADDR <= 12'h000;
      MEM_DQM <= 2'h3;
      MEM_DQ_OUT <= 16'h0000;
      MEM_DQ_OE <= 1'b0;
      rd_pipe <= 6'h00;
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      RD_DATA <= 16'h0000;
      RD_VALID <= 1'b0;
    end else begin
      {MEM_CS_N, MEM_RAS_N, MEM_CAS_N, MEM_WE_N} <= cmd;
      MEM_ADDR <= addr;
      // Write mask acts in the data cycle, read mask on read data later
      MEM_DQM <= (cmd == CMD_WR) ? REQ_MASK : 2'h0;
      MEM_DQ_OUT <= REQ_WDATA;
      MEM_DQ_OE <= (cmd == CMD_WR);
      // Pad sampled via two flops; adds two cycles to the read latency
      dq_s1 <= MEM_DQ_IN;
      dq_s2 <= dq_s1;
      // Pin register, CAS latency, two sync flops and output register: seven edges from take to valid
      rd_pipe <= {rd_pipe[4:0], (cmd == CMD_RD)};
      RD_VALID <= rd_pipe[5];
      RD_DATA <= dq_s2;
    end
  end

  // Pin period fixed by clock: 40 ns exceeds the 8 ns floor
  a_mode_gap: assert property (@(posedge CLK) disable iff (RST)
    cmd == CMD_MRS |=> cmd == CMD_NOP) else $error("command inside mode load gap");
  a_rrd_gap: assert property (@(posedge CLK) disable iff (RST)
    cmd == CMD_ACT |-> rrd_cnt == 8'h00) else $error("activates too close");
  a_ref_idle: assert property (@(posedge CLK) disable iff (RST)
    cmd == CMD_REF |-> open_bank == 2'b00) else $error("refresh with open bank");
  a_col_open: assert property (@(posedge CLK) disable iff (RST)
    (cmd == CMD_RD || cmd == CMD_WR) |-> open_bank[addr[BANK_SELECT_BIT]])
    else $error("column to closed bank");
  a_init_first: assert property (@(posedge CLK) disable iff (RST)
    !INIT_DONE |-> !REQ_READY) else $error("request before init");
  a_cke_gap: assert property (@(posedge CLK) disable iff (RST)
    $rose(MEM_CKE) |-> cmd == CMD_NOP [*2]) else $error("command during cke recovery");
endmodule

// ### include/sdc_bank_if.sv
`timescale 1ns/1ps
interface sdc_bank_if;
  logic act;
  logic pre;
  logic col_wr;
  logic auto_pre;
  logic can_act;
  logic can_pre;
  logic can_col;
  modport ctl (output act, pre, col_wr, auto_pre, input can_act, can_pre, can_col);
  modport bank (input act, pre, col_wr, auto_pre, output can_act, can_pre, can_col);
endinterface

// ### include/sdc_pkg.sv
package sdc_pkg;
  // ****************************************
  // Timing figures, as printed
  // ****************************************
  localparam int CLK_PERIOD_PS = 40000;
  localparam int ROW_CYCLE_PS = 63000;
  localparam int ACT_TO_PRE_PS = 42000;
  localparam int ACT_TO_PRE_MAX_PS = 100000000;
  localparam int PRE_TO_ACT_PS = 20000;
  localparam int ACT_TO_COL_PS = 16000;
  localparam int ACT_TO_ACT_PS = 14000;
  localparam int CLOCK_ENABLE_RECOVERY_PS = 40000 + 3000;
  localparam int WRITE_RECOVERY_CYC = 1;
  localparam int MODE_LOAD_RECOVERY_CYC = 2;
  localparam int POWERUP_WAIT_US = 100;
  localparam int REFRESH_ROWS = 4096;
  localparam int REFRESH_PERIOD_MS = 64;
  localparam int READ_MASK_LATENCY = 2;
  localparam int WRITE_MASK_LATENCY = 0;
  localparam int STOP_WRITE_IGNORE_DELAY = 0;
  localparam int CAS_LATENCY = 3;
  localparam int INIT_REFRESHES = 2;
  // ****************************************
  // Derived cycle counts (minimums round up, maximums down)
  // ****************************************
  function automatic int up_cyc(input int ps);
    return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction
  localparam int RC_CYC = up_cyc(ROW_CYCLE_PS);
  localparam int RAS_CYC = up_cyc(ACT_TO_PRE_PS);
  localparam int RAS_MAX_CYC = ACT_TO_PRE_MAX_PS / CLK_PERIOD_PS;
  localparam int RP_CYC = up_cyc(PRE_TO_ACT_PS);
  localparam int RCD_CYC = up_cyc(ACT_TO_COL_PS);
  localparam int RRD_CYC = up_cyc(ACT_TO_ACT_PS);
  localparam int CKA_CYC = up_cyc(CLOCK_ENABLE_RECOVERY_PS);
  localparam int DAL_CYC = 1 + RP_CYC;
  localparam int POWERUP_CYC = POWERUP_WAIT_US * 1000000 / CLK_PERIOD_PS;
  localparam int REFRESH_INTERVAL_CYC =
    (REFRESH_PERIOD_MS * 1000) / REFRESH_ROWS * 1000000 / CLK_PERIOD_PS;
  // ****************************************
  // Pin and command encodings {cs_n,ras_n,cas_n,we_n}
  // ****************************************
  localparam int AUTOPRECHARGE_SELECT_BIT = 10;
  localparam int BANK_SELECT_BIT = 11;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_STOP = 4'h6;
  localparam logic [11:0] MODE_WORD = 12'h031;
  localparam logic [1:0] REQ_RD = 2'h1;
  localparam logic [1:0] REQ_WR = 2'h2;
endpackage
